// >>> design/digout_consts.svh
/*
  Constants for the threshold digital output block: register offsets,
  field positions, reset values and value limits.
  Assumes inclusion by bare name from the package and the top module.
*/
`ifndef DIGOUT_CONSTS_SVH
`define DIGOUT_CONSTS_SVH

// ----------------------------------------------------------------------
// channel count and register map
// ----------------------------------------------------------------------
`define NUM_CHANNELS      3
`define CH_FIELD_HI       7
`define CH_FIELD_LO       4
`define OFF_SOURCE        4'h0
`define OFF_CONFIG        4'h4
`define OFF_THRESHOLD     4'h8
`define OFF_STATUS        4'hC

// ----------------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------------
`define CFG_INVERT_BIT    0
`define CFG_ABS_BIT       1
`define STATUS_ON_BIT     0
`define SOURCE_WIDTH      10
`define THRESHOLD_WIDTH   16

// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define SOURCE_RST_ONE    10'h04D
`define SOURCE_RST_TWO    10'h07A
`define SOURCE_RST_THREE  10'h07D
`define SOURCE_MAX        32'h0000027F
`define THRESHOLD_RST     16'h0000
`define THRESHOLD_MAX     32'sh00007530
`define THRESHOLD_MIN     32'shFFFF8AD0
`define INVERT_RST        1'b0
`define ABS_RST           1'b1

`endif

// >>> design/digout_pkg.sv
/*
  Types shared by the threshold digital output block.
  Assumes digout_consts.svh is on the include path.
*/
`default_nettype none

`include "digout_consts.svh"

package digout_pkg;

  // per channel settings written by software
  typedef struct packed {
    logic [`SOURCE_WIDTH-1:0]    source;
    logic                        invert;
    logic                        absolute_value_enable;
    logic [`THRESHOLD_WIDTH-1:0] threshold;
  } chan_cfg_s;

  typedef chan_cfg_s [`NUM_CHANNELS-1:0] cfg_array_t;

  // whole register state of the top module
  typedef struct packed {
    cfg_array_t  cfg;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } top_state_s;

  // state of one channel
  typedef struct packed {
    logic terminal;
  } chan_state_s;

endpackage

`default_nettype wire

// >>> design/digout_channel.sv
/*
  One output channel: optional absolute value, strict greater-than test
  against a signed threshold, optional inversion, registered terminal.
  Assumes source value and logic flag come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module digout_channel
  import digout_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire digout_pkg::chan_cfg_s cfg,
  input  wire logic [31:0]        source_value,
  input  wire logic               source_is_logic,
  output logic                    terminal
);
  import digout_pkg::*;

  chan_state_s      st_reg;
  chan_state_s      st_next;
  logic signed [32:0] tested;
  logic signed [32:0] limit;

  // ----------------------------------------------------------------------
  // compare and drive
  // ----------------------------------------------------------------------
  // logic sources reduce to one or zero before the test
  always_comb
  begin
    st_next = st_reg;
    if (source_is_logic)
      tested = (source_value != 32'h00000000) ? 33'sh1 : 33'sh0;
    else
      tested = $signed({source_value[31], source_value});
    if (cfg.absolute_value_enable && tested < 33'sh0)
      tested = -tested;
    limit = $signed({{17{cfg.threshold[15]}}, cfg.threshold});
    st_next.terminal = (tested > limit) ^ cfg.invert;
  end

  // output registered every clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign terminal = st_reg.terminal;

endmodule

`default_nettype wire

// >>> design/digout_top.sv
/*
  Three-channel threshold digital output block with an APB register
  slave. Each channel reads an internal parameter chosen by its source
  index and drives a 24 V output terminal through a registered output.
  Register map, four words per channel, channel number in paddr[7:4]:
    +0x0 source index, 10 bits, read/write, refused above 639
    +0x4 config: bit 0 invert, bit 1 absolute value, read/write
    +0x8 threshold, signed hundredths of a percent, sign-extended on read
    +0xC status: bit 0 is the terminal state, read only
  Channels 3 to 15 and unaligned offsets answer with pslverr.
  Assumes the parameter store answers source_value for each index on
  the same clock, and that the APB master follows the usual protocol.
  Assumes the master accepts zero wait states: pready rises in the
  first access cycle of every transfer and lasts one cycle.
  Assumes source_value is a signed number in hundredths of a percent,
  and that source_is_logic marks one-bit parameters.
*/
// Behaviour
// - each channel picks its source parameter by an index from 0 to 639
// - absolute-value option strips the sign before the comparison
// - invert option drives the complement of the result, else unchanged
// - true final result drives terminal high (24 V), false drives 0 V
// - reset source indices are 77, 122 and 125
// - logic sources present one for true and zero for false
// - percent value 0.00 is logic zero, any nonzero value logic one
`timescale 1ns/1ps
`default_nettype none

`include "digout_consts.svh"

module digout_top
  import digout_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [9:0]       source_index_one,
  output logic [9:0]       source_index_two,
  output logic [9:0]       source_index_three,
  input  wire logic [31:0] source_value_one,
  input  wire logic [31:0] source_value_two,
  input  wire logic [31:0] source_value_three,
  input  wire logic        source_is_logic_one,
  input  wire logic        source_is_logic_two,
  input  wire logic        source_is_logic_three,
  output logic             output_terminal_one,
  output logic             output_terminal_two,
  output logic             output_terminal_three
);
  import digout_pkg::*;

  top_state_s               st_reg;
  top_state_s               st_next;
  logic [31:0]              value_vec [`NUM_CHANNELS];
  logic [`NUM_CHANNELS-1:0] logic_vec;
  logic [`NUM_CHANNELS-1:0] term_vec;
  logic                     setup_phase;
  logic                     write_commit;

  // ----------------------------------------------------------------------
  // reset value of the register state
  // ----------------------------------------------------------------------
  function automatic top_state_s reset_state();
    top_state_s s;
    s = '0;
    for (int i = 0; i < `NUM_CHANNELS; i++)
    begin
      s.cfg[i].invert                = `INVERT_RST;
      s.cfg[i].absolute_value_enable = `ABS_RST;
      s.cfg[i].threshold             = `THRESHOLD_RST;
    end
    s.cfg[0].source = `SOURCE_RST_ONE;
    s.cfg[1].source = `SOURCE_RST_TWO;
    s.cfg[2].source = `SOURCE_RST_THREE;
    return s;
  endfunction

  // ----------------------------------------------------------------------
  // write value checks
  // ----------------------------------------------------------------------
  // a source index must name a parameter that exists
  function automatic logic source_ok(input logic [31:0] d);
    return d <= `SOURCE_MAX;
  endfunction

  // a threshold must stay within plus or minus 300.00 percent
  function automatic logic threshold_ok(input logic [31:0] d);
    return ($signed(d) >= `THRESHOLD_MIN) && ($signed(d) <= `THRESHOLD_MAX);
  endfunction

  // ----------------------------------------------------------------------
  // apb phase decode
  // ----------------------------------------------------------------------
  // setup cycle: answer is decoded and latched for the access cycle
  assign setup_phase  = psel && !penable;
  // commit edge: access cycle with ready high and no error pending
  assign write_commit = psel && penable && st_reg.pready && pwrite && !st_reg.pslverr;

  // ----------------------------------------------------------------------
  // apb slave: decode in setup, answer in access, write on completion
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [3:0]  ch;
    logic [3:0]  off;
    logic        hit;
    logic [31:0] rd;
    ch      = paddr[`CH_FIELD_HI:`CH_FIELD_LO];
    off     = paddr[3:0];
    hit     = 1'b0;
    rd      = 32'h00000000;
    st_next = st_reg;
    st_next.pready  = 1'b0;
    // read word of the addressed register; unmapped offsets clear hit
    for (int i = 0; i < `NUM_CHANNELS; i++)
    begin
      if (ch == 4'(i))
      begin
        hit = 1'b1;
        unique case (off)
          `OFF_SOURCE:    rd = {22'h0, st_reg.cfg[i].source};
          `OFF_CONFIG:    rd = {30'h0, st_reg.cfg[i].absolute_value_enable,
                                st_reg.cfg[i].invert};
          `OFF_THRESHOLD: rd = {{16{st_reg.cfg[i].threshold[15]}}, st_reg.cfg[i].threshold};
          `OFF_STATUS:    rd = {31'h0, term_vec[i]};
          default:        hit = 1'b0;
        endcase
      end
    end
    // setup phase: latch answer so it leaves a flop
    if (setup_phase)
    begin
      st_next.pready  = 1'b1;
      st_next.pslverr = !hit;
      st_next.prdata  = hit ? rd : 32'h00000000;
    end
    // completing edge of a good write
    if (write_commit)
    begin
      for (int i = 0; i < `NUM_CHANNELS; i++)
      begin
        if (ch == 4'(i))
        begin
          unique case (off)
            `OFF_SOURCE:
              if (source_ok(pwdata))
                st_next.cfg[i].source = pwdata[`SOURCE_WIDTH-1:0];
            `OFF_CONFIG:
            begin
              st_next.cfg[i].invert                = pwdata[`CFG_INVERT_BIT];
              st_next.cfg[i].absolute_value_enable = pwdata[`CFG_ABS_BIT];
            end
            `OFF_THRESHOLD:
              if (threshold_ok(pwdata))
                st_next.cfg[i].threshold = pwdata[`THRESHOLD_WIDTH-1:0];
            default: ;                                                 // status is read only
          endcase
        end
      end
    end
  end

  // register the whole state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= reset_state();
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------------
  // gather per channel inputs
  assign value_vec[0] = source_value_one;
  assign value_vec[1] = source_value_two;
  assign value_vec[2] = source_value_three;
  assign logic_vec    = {source_is_logic_three, source_is_logic_two, source_is_logic_one};

  // one compare channel each; terminal follows its settings one clock
  // after a register write, and the status word reads the same flop
  for (genvar g = 0; g < `NUM_CHANNELS; g++)
  begin : g_chan
    digout_channel u_chan
    (
      .pclk            (pclk),
      .presetn         (presetn),
      .cfg             (st_reg.cfg[g]),
      .source_value    (value_vec[g]),
      .source_is_logic (logic_vec[g]),
      .terminal        (term_vec[g])
    );
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // bus answer straight from the state flops
  assign prdata                = st_reg.prdata;
  assign pready                = st_reg.pready;
  assign pslverr               = st_reg.pslverr;

  // source selects for the parameter store
  assign source_index_one      = st_reg.cfg[0].source;
  assign source_index_two      = st_reg.cfg[1].source;
  assign source_index_three    = st_reg.cfg[2].source;

  // terminals straight from the channel flops
  assign output_terminal_one   = term_vec[0];
  assign output_terminal_two   = term_vec[1];
  assign output_terminal_three = term_vec[2];

endmodule

`default_nettype wire

// >>> testbench/param_store.sv
/* parameter store model: value and logic flag per source index.
   assumes the bench fills mem and is_lg by hierarchy. */
`timescale 1ns/1ps
`default_nettype none
module param_store (
  input  wire logic [9:0] idx,
  output logic [31:0]     val,
  output logic            lg
);
  logic [31:0] mem [0:639];
  logic        is_lg [0:639];
  // out of range index gives a moving junk pattern
  always_comb
  begin
    val = 32'h5A5A5A5A ^ {22'h0, idx};
    lg  = idx[0];
    if (idx <= 10'h27F)
    begin
      val = mem[idx];
      lg  = is_lg[idx];
    end
  end
endmodule
`default_nettype wire

// >>> testbench/digout_top_sva.sv
/* checker for digout_top ports.
   assumes binding to digout_top with matching port names. */
`timescale 1ns/1ps
`default_nettype none
module digout_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [9:0]  source_index_one,
  input wire logic [9:0]  source_index_two,
  input wire logic [31:0] source_value_one,
  input wire logic [31:0] source_value_two,
  input wire logic        output_terminal_one,
  input wire logic        output_terminal_two
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [1:0] hit;
  logic [1:0] touched_reg;
  // config or threshold write per channel
  assign hit[0] = psel && penable && pready && pwrite && (paddr == 8'h04 || paddr == 8'h08);
  assign hit[1] = psel && penable && pready && pwrite && (paddr == 8'h14 || paddr == 8'h18);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      touched_reg <= 2'h0;
    else
      touched_reg <= touched_reg | hit;
  end
  sequence s_write(a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_reset_index: assert property ($rose(presetn) |->
    source_index_one == 10'h04D && source_index_two == 10'h07A)
    else $error("wrong source index after reset");
  a_index_range: assert property (source_index_one <= 10'h27F && source_index_two <= 10'h27F)
    else $error("source index out of range");
  a_write_source: assert property (s_write(8'h00) ##0 (pwdata <= 32'h27F)
    |=> source_index_one == $past(pwdata[9:0])) else $error("source write lost");
  a_source_refused: assert property (s_write(8'h00) ##0 (pwdata > 32'h27F)
    |=> $stable(source_index_one)) else $error("bad source taken");
  a_default_one: assert property (!touched_reg[0] && !hit[0]
    |=> output_terminal_one == ($past(source_value_one) != 32'h0))
    else $error("terminal one wrong at defaults");
  a_default_two: assert property (!touched_reg[1] && !hit[1]
    |=> output_terminal_two == ($past(source_value_two) != 32'h0))
    else $error("terminal two wrong at defaults");
endmodule
bind digout_top digout_checker u_digout_checker (
  .pclk                (pclk),
  .presetn             (presetn),
  .psel                (psel),
  .penable             (penable),
  .pwrite              (pwrite),
  .paddr               (paddr),
  .pwdata              (pwdata),
  .pready              (pready),
  .source_index_one    (source_index_one),
  .source_index_two    (source_index_two),
  .source_value_one    (source_value_one),
  .source_value_two    (source_value_two),
  .output_terminal_one (output_terminal_one),
  .output_terminal_two (output_terminal_two)
);
`default_nettype wire

// >>> testbench/test_threshold_digital_outputs.sv
/* bench for digout_top: apb tasks, table of threshold cases.
   assumes param_store models the parameter source. */
`timescale 1ns/1ps
`default_nettype none
module test_threshold_digital_outputs;
  import digout_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, v1, v2, v3;
  logic pready, pslverr, err, l1, l2, l3, t1, t2, t3;
  logic [9:0] i1, i2, i3;
  int bad_count = 0, comparisons = 0;
  logic [31:0] vals [10] = '{32'hFFFFEC78, 32'hFFFFEC78, 32'h7D0, 32'h7D1, 32'h7D1,
                             32'h1, 32'h0, 32'h5, 32'h5, 32'hFFFFFF9C};
  logic [31:0] thrs [10] = '{32'h7D0, 32'h7D0, 32'h7D0, 32'h7D0, 32'h7D0,
                             32'h0, 32'h0, 32'h0, 32'h1, 32'hFFFFFF38};
  logic [1:0] cfgs [10] = '{2'h2, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0};
  logic lgs [10] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic exps [10] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  always #2 pclk = ~pclk;
  digout_top u_digout_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .source_index_one(i1), .source_index_two(i2), .source_index_three(i3),
    .source_value_one(v1), .source_value_two(v2), .source_value_three(v3),
    .source_is_logic_one(l1), .source_is_logic_two(l2), .source_is_logic_three(l3),
    .output_terminal_one(t1), .output_terminal_two(t2), .output_terminal_three(t3));
  param_store u_param_store_one (.idx(i1), .val(v1), .lg(l1));
  param_store u_param_store_two (.idx(i2), .val(v2), .lg(l2));
  param_store u_param_store_three (.idx(i3), .val(v3), .lg(l3));
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial
  begin
    u_param_store_one.mem[77] = 32'hFFFFFFF6;
    u_param_store_one.is_lg[77] = 1'b0;
    u_param_store_two.mem[122] = 32'h1;
    u_param_store_two.is_lg[122] = 1'b1;
    u_param_store_three.mem[125] = 32'h0;
    u_param_store_three.is_lg[125] = 1'b1;
    u_param_store_one.mem[639] = 32'h0;
    u_param_store_one.is_lg[639] = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    check({29'h0, t1, t2, t3}, 32'h6);
    check({2'h0, i1, i2, i3}, {2'h0, 10'h04D, 10'h07A, 10'h07D});
    apb(0, 8'h00, 0); check(rd, 32'h4D);
    apb(0, 8'h10, 0); check(rd, 32'h7A);
    apb(0, 8'h20, 0); check(rd, 32'h7D);
    apb(0, 8'h04, 0); check(rd, 32'h2);
    apb(0, 8'h08, 0); check(rd, 32'h0);
    $display("test reset done");
    apb(1, 8'h00, 32'h27F);
    apb(1, 8'h00, 32'h280);
    apb(0, 8'h00, 0); check(rd, 32'h27F);
    check({22'h0, i1}, 32'h27F);
    apb(1, 8'h08, 32'hFFFF8AD0);
    apb(1, 8'h08, 32'hFFFF8ACF);
    apb(0, 8'h08, 0); check(rd, 32'hFFFF8AD0);
    apb(0, 8'h30, 0); check({31'h0, err}, 32'h1);
    $display("test ranges done");
    for (int i = 0; i < 10; i++)
    begin
      u_param_store_one.mem[639] <= vals[i];
      u_param_store_one.is_lg[639] <= lgs[i];
      apb(1, 8'h04, {30'h0, cfgs[i]});
      apb(1, 8'h08, thrs[i]);
      repeat (2) @(posedge pclk);
      check({31'h0, t1}, {31'h0, exps[i]});
      apb(0, 8'h0C, 0); check(rd, {31'h0, exps[i]});
    end
    $display("test compare done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    check({2'h0, i1, i2, i3}, {2'h0, 10'h04D, 10'h07A, 10'h07D});
    check({29'h0, t1, t2, t3}, 32'h6);
    apb(0, 8'h04, 0);
    check(rd, 32'h2);
    apb(0, 8'h08, 0);
    check(rd, 32'h0);
    $display("test reset again done");
    end_of_test;
  end
  // watchdog
  initial
  begin
    repeat (3000) @(posedge pclk);
    bad_count++;
    $display("timeout");
    end_of_test;
  end
endmodule
`default_nettype wire
